// File: verilog/fpxu_defines.vh
// Constants for the single-precision multiply/divide/compare/convert unit.
// Included by fpxu_unit.v; definitions only.
`ifndef FPXU_DEFINES_VH
`define FPXU_DEFINES_VH

// Operation codes on op_code
`define FPXU_OP_MUL       3'h0
`define FPXU_OP_DIV       3'h1
`define FPXU_OP_CMP       3'h2
`define FPXU_OP_FLT       3'h3
`define FPXU_OP_FINT      3'h4

// Compare select codes
`define FPXU_CMP_UN       3'h0
`define FPXU_CMP_LT       3'h1
`define FPXU_CMP_EQ       3'h2
`define FPXU_CMP_LE       3'h3
`define FPXU_CMP_GT       3'h4
`define FPXU_CMP_NE       3'h5
`define FPXU_CMP_GE       3'h6

// Values
`define FPXU_QNAN         32'hffc00000
`define FPXU_CAUSE_FP     5'h06
`define FPXU_EXP_MAX      8'hff

// Flag bit positions in the 5-bit flag vector
`define FPXU_FLG_DO       0
`define FPXU_FLG_UNDER    1
`define FPXU_FLG_OVER     2
`define FPXU_FLG_DIVZ     3
`define FPXU_FLG_IO       4

// Register byte offsets and control enable reset value
`define FPXU_REG_CTRL     4'h0
`define FPXU_REG_STATUS   4'h4
`define FPXU_REG_CAUSE    4'h8
`define FPXU_CTRL_RESET   1'b1

// Latencies in cycles per area level 0 / 1 / 2
`define FPXU_LAT_MUL_A0   5'd4
`define FPXU_LAT_MUL_A1   5'd6
`define FPXU_LAT_MUL_A2   5'd1
`define FPXU_LAT_DIV_A0   5'd28
`define FPXU_LAT_DIV_A1   5'd30
`define FPXU_LAT_DIV_A2   5'd24
`define FPXU_LAT_CMP_A0   5'd1
`define FPXU_LAT_CMP_A1   5'd3
`define FPXU_LAT_CMP_A2   5'd1
`define FPXU_LAT_FLT_A0   5'd4
`define FPXU_LAT_FLT_A1   5'd6
`define FPXU_LAT_FLT_A2   5'd1
`define FPXU_LAT_FINT_A0  5'd5
`define FPXU_LAT_FINT_A1  5'd7
`define FPXU_LAT_FINT_A2  5'd2

`endif

// File: verilog/fpxu_unit.v
// Floating-point multiply, divide, compare and int/float conversion unit.
// Assumes an issue stage that holds op_valid and operands until op_ready,
// a register file that writes res_data only when res_write is high, and an
// AXI4-Lite master for the status/cause/control registers.
// Notes on behaviour
// - Denormal operand: qNaN or zero, denormal flag
// - Multiply sNaN or zero times infinity: invalid
// - Quiet NaN operand returns qNaN, no flags
// - Denormal product gives signed zero, underflow
// - Overflowing product gives signed infinity, overflow
// - On exception destination is not written
// - Multiply latency 4, 6 or 1 cycles
// - Divide computes source two over source one
// - Divide sNaN, 0/0, inf/inf: invalid
// - Zero divisor, finite dividend: infinity, divide-zero
// - Quotient underflow zero, overflow infinity, flagged
// - Divide latency 28, 30 or 24 cycles
// - Compare source two against one by select
// - Signalling NaN compare: invalid, un/ne true
// - Quiet NaN: ordered relations invalid, others silent
// - Compare latency 1, 3 or 1 cycles
// - Int to float rounds, changes no flags
// - Int to float latency 4, 6, 1
// - Float to int truncates; NaN invalid
// - Infinite or out-of-range float to int invalid
// - Float to int latency 5, 7, 2
// - Level above zero basic ops; conversions level 2
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "fpxu_defines.vh"

module fpxu_unit #(
  parameter FP_LEVEL   = 2,
  parameter AREA_LEVEL = 0,
  parameter ADDR_W     = 4
) (
  input  wire              clk_sys,
  input  wire              sys_rst,
  input  wire              ce,
  input  wire              op_valid,
  output wire              op_ready,
  output wire              op_unsupported,
  input  wire [2:0]        op_code,
  input  wire [2:0]        compare_select,
  input  wire [31:0]       source_one,
  input  wire [31:0]       source_two,
  output wire              res_valid,
  output wire              res_write,
  output wire [31:0]       res_data,
  output wire [4:0]        res_flags,
  output wire              exc_valid,
  output wire [4:0]        exception_cause,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output wire [1:0]        s_axi_bresp,
  output wire              s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output wire [31:0]       s_axi_rdata,
  output wire [1:0]        s_axi_rresp,
  output wire              s_axi_rvalid,
  input  wire              s_axi_rready
);

  // Rounds a normalised mantissa to nearest-even; returns {uf, of, value}
  function [33:0] fpxu_pack;
    input              sgn;
    input signed [9:0] ex;
    input [23:0]       man;
    input              grd;
    input              stk;
    reg [24:0]         m2;
    reg signed [9:0]   e2;
    begin
      m2 = {1'b0, man} + {24'h000000, grd & (stk | man[0])};
      e2 = m2[24] ? ex + 10'sd1 : ex;
      if (m2[24])
        m2 = m2 >> 1;
      if (e2 >= 10'sd255)
        fpxu_pack = {2'b01, sgn, `FPXU_EXP_MAX, 23'h000000};
      else if (e2 <= 10'sd0)
        fpxu_pack = {2'b10, sgn, 31'h00000000};
      else
        fpxu_pack = {2'b00, sgn, e2[7:0], m2[22:0]};
    end
  endfunction

  function [4:0] fpxu_msb;
    input [31:0] v;
    integer      i;
    begin
      fpxu_msb = 5'h00;
      for (i = 0; i < 32; i = i + 1)
        if (v[i])
          fpxu_msb = i[4:0];
    end
  endfunction

  function [4:0] fpxu_lat;
    input [2:0] op;
    begin
      case (op)
        `FPXU_OP_MUL:  fpxu_lat = (AREA_LEVEL == 1) ? `FPXU_LAT_MUL_A1 :
                                  (AREA_LEVEL == 2) ? `FPXU_LAT_MUL_A2 : `FPXU_LAT_MUL_A0;
        `FPXU_OP_DIV:  fpxu_lat = (AREA_LEVEL == 1) ? `FPXU_LAT_DIV_A1 :
                                  (AREA_LEVEL == 2) ? `FPXU_LAT_DIV_A2 : `FPXU_LAT_DIV_A0;
        `FPXU_OP_CMP:  fpxu_lat = (AREA_LEVEL == 1) ? `FPXU_LAT_CMP_A1 :
                                  (AREA_LEVEL == 2) ? `FPXU_LAT_CMP_A2 : `FPXU_LAT_CMP_A0;
        `FPXU_OP_FLT:  fpxu_lat = (AREA_LEVEL == 1) ? `FPXU_LAT_FLT_A1 :
                                  (AREA_LEVEL == 2) ? `FPXU_LAT_FLT_A2 : `FPXU_LAT_FLT_A0;
        default:       fpxu_lat = (AREA_LEVEL == 1) ? `FPXU_LAT_FINT_A1 :
                                  (AREA_LEVEL == 2) ? `FPXU_LAT_FINT_A2 : `FPXU_LAT_FINT_A0;
      endcase
    end
  endfunction

  reg        busy_q;
  reg [4:0]  cnt_q;
  reg [31:0] res_q;
  reg [4:0]  flg_q;
  reg        exc_q;
  reg        en_q;
  reg [4:0]  status_q;
  reg [4:0]  cause_q;

  // Operand classification, source two is b, source one is a
  wire [7:0]  ea = source_one[30:23];
  wire [7:0]  eb = source_two[30:23];
  wire [22:0] fa = source_one[22:0];
  wire [22:0] fb = source_two[22:0];
  wire        sa = source_one[31];
  wire        sb = source_two[31];
  wire        a_den  = (ea == 8'h00) && (fa != 23'h000000);
  wire        b_den  = (eb == 8'h00) && (fb != 23'h000000);
  wire        a_zero = (ea == 8'h00) && (fa == 23'h000000);
  wire        b_zero = (eb == 8'h00) && (fb == 23'h000000);
  wire        a_inf  = (ea == `FPXU_EXP_MAX) && (fa == 23'h000000);
  wire        b_inf  = (eb == `FPXU_EXP_MAX) && (fb == 23'h000000);
  wire        a_nan  = (ea == `FPXU_EXP_MAX) && (fa != 23'h000000);
  wire        b_nan  = (eb == `FPXU_EXP_MAX) && (fb != 23'h000000);
  wire        any_snan = (a_nan & ~fa[22]) | (b_nan & ~fb[22]);
  wire        any_qnan = (a_nan & fa[22]) | (b_nan & fb[22]);
  wire        sp = sa ^ sb;
  wire [23:0] ma = {1'b1, fa};
  wire [23:0] mb = {1'b1, fb};

  // Multiply datapath
  wire [47:0]       prod = ma * mb;
  wire signed [9:0] emul = $signed({2'b00, ea}) + $signed({2'b00, eb}) - 10'sd127;
  wire [33:0]       mul_pk = prod[47] ? fpxu_pack(sp, emul + 10'sd1, prod[47:24], prod[23], |prod[22:0])
                                      : fpxu_pack(sp, emul, prod[46:23], prod[22], |prod[21:0]);

  // Divide datapath: quotient lies between 2^25 and 2^27
  wire [49:0]       num  = {mb, 26'h0000000};
  wire [49:0]       quo  = num / {26'h0000000, ma};
  wire [49:0]       rem  = num % {26'h0000000, ma};
  wire              rnz  = (rem != 50'h0);
  wire signed [9:0] ediv = $signed({2'b00, eb}) - $signed({2'b00, ea}) + 10'sd127;
  wire [33:0]       div_pk = quo[26] ? fpxu_pack(sp, ediv, quo[26:3], quo[2], quo[1] | quo[0] | rnz)
                                     : fpxu_pack(sp, ediv - 10'sd1, quo[25:2], quo[1], quo[0] | rnz);

  // Integer to float
  wire [31:0]       imag = sa ? (~source_one + 32'h00000001) : source_one;
  wire [4:0]        ipos = fpxu_msb(imag);
  wire [31:0]       inrm = imag << (5'd31 - ipos);
  wire [33:0]       flt_pk = fpxu_pack(sa, $signed({5'b00000, ipos}) + 10'sd127, inrm[31:8], inrm[7], |inrm[6:0]);

  // Float to integer by truncation
  wire [55:0]       fbig = {32'h00000000, ma} << (ea - 8'd127);
  wire [31:0]       ftru = fbig[54:23];
  wire              f_small = (ea < 8'd127);
  wire              f_edge  = (ea == 8'd158) && sa && (fa == 23'h000000);
  wire              f_range = (ea > 8'd158) || ((ea == 8'd158) && !f_edge);

  // Ordered compare of source two against source one
  wire [31:0] ka = sa ? ~source_one : (source_one | 32'h80000000);
  wire [31:0] kb = sb ? ~source_two : (source_two | 32'h80000000);
  wire        c_eq = (source_one == source_two) || (a_zero && b_zero);
  wire        c_lt = !c_eq && (kb < ka);
  wire        c_gt = !c_eq && !c_lt;
  wire        sel_unne = (compare_select == `FPXU_CMP_UN) || (compare_select == `FPXU_CMP_NE);
  wire        sel_ord  = (compare_select == `FPXU_CMP_LT) || (compare_select == `FPXU_CMP_LE) ||
                         (compare_select == `FPXU_CMP_GT) || (compare_select == `FPXU_CMP_GE);

  wire supported = (FP_LEVEL > 0) &&
                   ((op_code == `FPXU_OP_MUL) || (op_code == `FPXU_OP_DIV) || (op_code == `FPXU_OP_CMP) ||
                    ((FP_LEVEL == 2) && ((op_code == `FPXU_OP_FLT) || (op_code == `FPXU_OP_FINT))));

  reg [31:0] nres;
  reg [4:0]  nflg;
  reg        nexc;
  reg        crel;

  always @*
  begin
    nres = `FPXU_QNAN;
    nflg = 5'h00;
    nexc = 1'b0;
    crel = 1'b0;
    case (op_code)
      `FPXU_OP_MUL:
      begin
        if (a_den || b_den)
        begin
          nflg[`FPXU_FLG_DO] = 1'b1;
          nexc = 1'b1;
        end
        else if (any_snan || (a_zero && b_inf) || (b_zero && a_inf))
        begin
          nflg[`FPXU_FLG_IO] = 1'b1;
          nexc = 1'b1;
        end
        else if (any_qnan)
          nres = `FPXU_QNAN;
        else if (a_inf || b_inf)
          nres = {sp, `FPXU_EXP_MAX, 23'h000000};
        else if (a_zero || b_zero)
          nres = {sp, 31'h00000000};
        else
        begin
          nres = mul_pk[31:0];
          nflg[`FPXU_FLG_UNDER] = mul_pk[33];
          nflg[`FPXU_FLG_OVER] = mul_pk[32];
          nexc = mul_pk[33] | mul_pk[32];
        end
      end
      `FPXU_OP_DIV:
      begin
        if (a_den || b_den)
        begin
          nflg[`FPXU_FLG_DO] = 1'b1;
          nexc = 1'b1;
        end
        else if (any_snan || (a_zero && b_zero) || (a_inf && b_inf))
        begin
          nflg[`FPXU_FLG_IO] = 1'b1;
          nexc = 1'b1;
        end
        else if (any_qnan)
          nres = `FPXU_QNAN;
        else if (a_zero && !b_inf)
        begin
          nres = {sp, `FPXU_EXP_MAX, 23'h000000};
          nflg[`FPXU_FLG_DIVZ] = 1'b1;
          nexc = 1'b1;
        end
        else if (b_inf || a_zero)
          nres = {sp, `FPXU_EXP_MAX, 23'h000000};
        else if (a_inf || b_zero)
          nres = {sp, 31'h00000000};
        else
        begin
          nres = div_pk[31:0];
          nflg[`FPXU_FLG_UNDER] = div_pk[33];
          nflg[`FPXU_FLG_OVER] = div_pk[32];
          nexc = div_pk[33] | div_pk[32];
        end
      end
      `FPXU_OP_CMP:
      begin
        if (a_den || b_den)
        begin
          nflg[`FPXU_FLG_DO] = 1'b1;
          nexc = 1'b1;
        end
        else if (any_snan)
        begin
          crel = sel_unne;
          nflg[`FPXU_FLG_IO] = 1'b1;
          nexc = 1'b1;
        end
        else if (any_qnan)
        begin
          crel = sel_unne;
          nflg[`FPXU_FLG_IO] = sel_ord;
          nexc = sel_ord;
        end
        else
        begin
          case (compare_select)
            `FPXU_CMP_UN: crel = 1'b0;
            `FPXU_CMP_LT: crel = c_lt;
            `FPXU_CMP_EQ: crel = c_eq;
            `FPXU_CMP_LE: crel = c_lt | c_eq;
            `FPXU_CMP_GT: crel = c_gt;
            `FPXU_CMP_NE: crel = !c_eq;
            `FPXU_CMP_GE: crel = c_gt | c_eq;
            default:      crel = 1'b0;
          endcase
        end
        nres = {31'h00000000, crel};
      end
      `FPXU_OP_FLT:
      begin
        if (source_one == 32'h00000000)
          nres = 32'h00000000;
        else
          nres = flt_pk[31:0];
      end
      `FPXU_OP_FINT:
      begin
        if (a_den)
        begin
          nflg[`FPXU_FLG_DO] = 1'b1;
          nexc = 1'b1;
        end
        else if (a_nan || a_inf || f_range)
        begin
          nflg[`FPXU_FLG_IO] = 1'b1;
          nexc = 1'b1;
        end
        else if (a_zero || f_small)
          nres = 32'h00000000;
        else
          nres = sa ? (~ftru + 32'h00000001) : ftru;
      end
      default:
        nres = `FPXU_QNAN;
    endcase
  end

  // Issue and latency counter; results are computed at issue and held
  wire take = ce & op_valid & op_ready;
  wire done = busy_q & (cnt_q == 5'd1);

  assign op_ready       = ~busy_q & en_q & supported;
  assign op_unsupported = op_valid & ~supported;
  assign res_valid      = done;
  assign res_write      = done & ~exc_q;
  assign res_data       = res_q;
  assign res_flags      = flg_q;
  assign exc_valid      = done & exc_q;
  assign exception_cause = cause_q;

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      busy_q <= 1'b0;
      cnt_q  <= 5'd0;
      res_q  <= 32'h00000000;
      flg_q  <= 5'h00;
      exc_q  <= 1'b0;
    end
    else if (ce)
    begin
      if (take)
      begin
        busy_q <= 1'b1;
        cnt_q  <= fpxu_lat(op_code);
        res_q  <= nres;
        flg_q  <= nflg;
        exc_q  <= nexc;
      end
      else if (busy_q)
      begin
        cnt_q <= cnt_q - 5'd1;
        if (done)
          busy_q <= 1'b0;
      end
    end
  end

  // AXI4-Lite slave
  reg              aw_got_q;
  reg              w_got_q;
  reg [ADDR_W-1:0] awaddr_q;
  reg [31:0]       wdata_q;
  reg [3:0]        wstrb_q;
  reg              bvalid_q;
  reg [1:0]        bresp_q;
  reg              rvalid_q;
  reg [1:0]        rresp_q;
  reg [31:0]       rdata_q;

  assign s_axi_awready = ce & ~aw_got_q & ~bvalid_q;
  assign s_axi_wready  = ce & ~w_got_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ce & ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  wire       wr_go  = aw_got_q & w_got_q & ~bvalid_q;
  wire [3:0] wr_off = awaddr_q[3:0];
  wire [4:0] clr    = (wr_go && wr_off == `FPXU_REG_STATUS && wstrb_q[0]) ? wdata_q[4:0] : 5'h00;
  wire [4:0] setf   = done ? flg_q : 5'h00;
  wire [3:0] rd_off = s_axi_araddr[3:0];

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= {ADDR_W{1'b0}};
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= 2'b00;
      rvalid_q <= 1'b0;
      rresp_q  <= 2'b00;
      rdata_q  <= 32'h00000000;
      en_q     <= `FPXU_CTRL_RESET;
      status_q <= 5'h00;
      cause_q  <= 5'h00;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= (wr_off == `FPXU_REG_CTRL || wr_off == `FPXU_REG_STATUS ||
                     wr_off == `FPXU_REG_CAUSE) ? 2'b00 : 2'b10;
        if (wr_off == `FPXU_REG_CTRL && wstrb_q[0])
          en_q <= wdata_q[0];
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
      // Sticky flags: a flag raised in the clearing cycle survives
      status_q <= (status_q & ~clr) | setf;
      if (done && exc_q)
        cause_q <= `FPXU_CAUSE_FP;
      if (s_axi_arvalid && s_axi_arready)
      begin
        rvalid_q <= 1'b1;
        rresp_q  <= 2'b00;
        case (rd_off)
          `FPXU_REG_CTRL:   rdata_q <= {26'h0000000, busy_q, 4'h0, en_q};
          `FPXU_REG_STATUS: rdata_q <= {27'h0000000, status_q};
          `FPXU_REG_CAUSE:  rdata_q <= {27'h0000000, cause_q};
          default:
          begin
            rdata_q <= 32'h00000000;
            rresp_q <= 2'b10;
          end
        endcase
      end
      else if (rvalid_q && s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

endmodule

// File: tb/fpxu_asserts.sv
// Port-level timing and result checks for fpxu_unit.
// Assumes ce stays high while operations are in flight.
`timescale 1ns/1ns
`include "fpxu_defines.vh"
module fpxu_asserts #(
  parameter AREA_LEVEL = 0
) (
  input wire        clk_sys,
  input wire        sys_rst,
  input wire        ce,
  input wire        op_valid,
  input wire        op_ready,
  input wire        op_unsupported,
  input wire [2:0]  op_code,
  input wire        res_valid,
  input wire        res_write,
  input wire [31:0] res_data,
  input wire [4:0]  res_flags,
  input wire        exc_valid,
  input wire [4:0]  exception_cause
);
  reg        pend_q;
  reg  [4:0] cnt_q;
  reg  [2:0] op_q;
  wire       take = ce & op_valid & op_ready;
  wire [4:0] lat;
  function [4:0] pick(input [4:0] l0, input [4:0] l1, input [4:0] l2);
    pick = (AREA_LEVEL == 1) ? l1 : (AREA_LEVEL == 2) ? l2 : l0;
  endfunction
  assign lat = (op_q == `FPXU_OP_MUL) ? pick(5'h04, 5'h06, 5'h01) :
               (op_q == `FPXU_OP_DIV) ? pick(5'h1c, 5'h1e, 5'h18) :
               (op_q == `FPXU_OP_CMP) ? pick(5'h01, 5'h03, 5'h01) :
               (op_q == `FPXU_OP_FLT) ? pick(5'h04, 5'h06, 5'h01) : pick(5'h05, 5'h07, 5'h02);
  // Counts cycles since the take edge so one check covers every latency
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pend_q <= 1'b0;
      cnt_q  <= 5'h00;
      op_q   <= 3'h0;
    end
    else if (take)
    begin
      pend_q <= 1'b1;
      cnt_q  <= 5'h01;
      op_q   <= op_code;
    end
    else if (pend_q)
    begin
      pend_q <= !res_valid;
      cnt_q  <= cnt_q + 5'h01;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  lat_hit_a: assert property (pend_q && cnt_q == lat |-> res_valid)
    else $error("result missing at its latency");
  res_time_a: assert property (res_valid |-> pend_q && cnt_q == lat)
    else $error("result outside its latency");
  flag_exc_a: assert property (res_valid |-> ((|res_flags) == exc_valid) && (res_write == !exc_valid))
    else $error("write enable disagrees with flags");
  cause_load_a: assert property ($rose(exc_valid) |=> exception_cause == 5'h06)
    else $error("cause not loaded");
  qnan_res_a: assert property (res_valid && op_q != `FPXU_OP_CMP && op_q != `FPXU_OP_FLT
    && (res_flags[0] || res_flags[4]) |-> res_data == 32'hffc00000)
    else $error("invalid result not the quiet pattern");
  cmp_bit_a: assert property (res_valid && op_q == `FPXU_OP_CMP |-> res_data[31:1] == 31'h0
    && !(res_flags[0] && res_data[0]))
    else $error("compare result not a single bit");
  flt_quiet_a: assert property (res_valid && op_q == `FPXU_OP_FLT |-> res_flags == 5'h00 && res_write)
    else $error("conversion raised a flag");
  range_res_a: assert property (res_valid && (res_flags[1] || res_flags[2]) |->
    res_data[30:0] == (res_flags[2] ? 31'h7f800000 : 31'h0))
    else $error("range result not signed zero or infinity");
  unsup_a: assert property (op_unsupported |-> !op_ready throughout ##1 1'b1)
    else $error("unsupported operation offered ready");
endmodule
bind fpxu_unit fpxu_asserts #(.AREA_LEVEL(AREA_LEVEL)) u_fpxu_asserts (
  .clk_sys, .sys_rst, .ce, .op_valid, .op_ready, .op_unsupported, .op_code, .res_valid,
  .res_write, .res_data, .res_flags, .exc_valid, .exception_cause
);

// File: tb/fpxu_issue_model.sv
// Issue stage and destination register standing in front of fpxu_unit.
// Assumes the bench pulses go for one cycle per operation.
`timescale 1ns/1ns
module fpxu_issue_model (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        go,
  input  wire        kill,
  input  wire [2:0]  go_op,
  input  wire [2:0]  go_sel,
  input  wire [31:0] go_a,
  input  wire [31:0] go_b,
  input  wire        op_ready,
  input  wire        res_write,
  input  wire [31:0] res_data,
  output reg         op_valid,
  output reg  [2:0]  op_code,
  output reg  [2:0]  compare_select,
  output reg  [31:0] source_one,
  output reg  [31:0] source_two,
  output reg  [31:0] dest_q
);
  initial {op_valid, op_code, compare_select, source_one, source_two, dest_q} = 103'h0;
  always @(posedge clk_sys)
  begin
    if (sys_rst | kill)
      op_valid <= 1'b0;
    else if (go)
      {op_valid, op_code, compare_select, source_one, source_two} <= {1'b1, go_op, go_sel, go_a, go_b};
    else if (op_valid && op_ready)
    begin
      // Released operands flip so a late sample shows as a wrong result
      op_valid   <= 1'b0;
      source_one <= ~source_one;
      source_two <= ~source_two;
    end
    if (res_write)
      dest_q <= res_data;
  end
endmodule

// File: tb/fpxu_unit_tb.sv
// Self-checking bench for fpxu_unit at area level 2.
// Assumes the issue model in front and the bound checker.
`timescale 1ns/1ns
module fpxu_unit_tb;
  reg         clk_sys = 1'b0, sys_rst = 1'b1, go = 1'b0, kill = 1'b0;
  reg  [2:0]  go_op = 3'h0, go_sel = 3'h0;
  reg  [31:0] go_a = 32'h0, go_b = 32'h0, s_axi_wdata = 32'h0;
  reg  [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire        ce = 1'b1;
  wire [3:0]  s_axi_wstrb = 4'hf;
  wire        op_valid, op_ready, op_unsupported, res_valid, res_write, exc_valid;
  wire [2:0]  op_code, compare_select;
  wire [31:0] source_one, source_two, res_data, dest_q, s_axi_rdata;
  wire [4:0]  res_flags, exception_cause;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  integer     n_fail = 0;
  integer     comparisons = 0;
  fpxu_unit #(.FP_LEVEL(2), .AREA_LEVEL(2), .ADDR_W(4)) u_fpxu_unit (
    .clk_sys, .sys_rst, .ce, .op_valid, .op_ready, .op_unsupported, .op_code, .compare_select,
    .source_one, .source_two, .res_valid, .res_write, .res_data, .res_flags, .exc_valid,
    .exception_cause, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  fpxu_issue_model u_fpxu_issue_model (
    .clk_sys, .sys_rst, .go, .kill, .go_op, .go_sel, .go_a, .go_b, .op_ready, .res_write,
    .res_data, .op_valid, .op_code, .compare_select, .source_one, .source_two, .dest_q
  );
  always #5 clk_sys = ~clk_sys;
  task stop_test;
  begin
    if (n_fail == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task chk_w(input [31:0] got, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task chk_f(input [4:0] got, input [4:0] exp);
    chk_w({27'h0, got}, {27'h0, exp});
  endtask
  task hang(input integer i);
  begin
    if (i >= 60)
    begin
      n_fail = n_fail + 1;
      stop_test;
    end
  end
  endtask
  task issue(input [2:0] op, input [2:0] sel, input [31:0] a, input [31:0] b, input [31:0] ed,
             input [4:0] ef);
    integer i;
    reg [31:0] prev;
  begin
    prev = dest_q;
    @(posedge clk_sys);
    {go, go_op, go_sel, go_a, go_b} <= {1'b1, op, sel, a, b};
    @(posedge clk_sys);
    go <= 1'b0;
    for (i = 0; i < 60; i = i + 1)
    begin
      @(posedge clk_sys);
      #1;
      if (res_valid === 1'b1)
        break;
    end
    hang(i);
    chk_w(res_data, ed);
    chk_f(res_flags, ef);
    @(posedge clk_sys);
    #1;
    chk_w(dest_q, (ef == 5'h00) ? ed : prev);
  end
  endtask
  task axi_wr(input [3:0] ad, input [31:0] d, input [1:0] er);
    integer i;
  begin
    @(posedge clk_sys);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {ad, d, 3'h7};
    for (i = 0; i < 60; i = i + 1)
    begin
      @(posedge clk_sys);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
        break;
    end
    s_axi_bready <= 1'b0;
    hang(i);
    chk_w({30'h0, s_axi_bresp}, {30'h0, er});
  end
  endtask
  task axi_rd(input [3:0] ad, input [31:0] ed, input [1:0] er);
    integer i;
  begin
    @(posedge clk_sys);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {ad, 2'h3};
    for (i = 0; i < 60; i = i + 1)
    begin
      @(posedge clk_sys);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
        break;
    end
    s_axi_rready <= 1'b0;
    hang(i);
    chk_w(s_axi_rdata, ed);
    chk_w({30'h0, s_axi_rresp}, {30'h0, er});
  end
  endtask
  task t_regs;
  begin
    axi_rd(4'h0, 32'h1, 2'h0);
    axi_rd(4'h8, 32'h0, 2'h0);
    axi_rd(4'hc, 32'h0, 2'h2);
    axi_wr(4'hc, 32'hffffffff, 2'h2);
  end
  endtask
  task t_mul;
  begin
    issue(3'h0, 3'h0, 32'h40000000, 32'h40400000, 32'h40c00000, 5'h00);
    issue(3'h0, 3'h0, 32'h00000001, 32'h7f800001, 32'hffc00000, 5'h01);
    axi_rd(4'h8, 32'h6, 2'h0);
    axi_rd(4'h4, 32'h1, 2'h0);
    axi_wr(4'h4, 32'h1f, 2'h0);
    axi_rd(4'h4, 32'h0, 2'h0);
    issue(3'h0, 3'h0, 32'h00000000, 32'h7f800000, 32'hffc00000, 5'h10);
    issue(3'h0, 3'h0, 32'h7f800001, 32'h3f800000, 32'hffc00000, 5'h10);
    issue(3'h0, 3'h0, 32'h7fc00000, 32'h3f800000, 32'hffc00000, 5'h00);
    issue(3'h0, 3'h0, 32'h80800000, 32'h00800000, 32'h80000000, 5'h02);
    issue(3'h0, 3'h0, 32'hff000000, 32'h7f000000, 32'hff800000, 5'h04);
  end
  endtask
  task t_div;
  begin
    issue(3'h1, 3'h0, 32'h40000000, 32'h40c00000, 32'h40400000, 5'h00);
    issue(3'h1, 3'h0, 32'h00000000, 32'h00000000, 32'hffc00000, 5'h10);
    issue(3'h1, 3'h0, 32'h7f800000, 32'hff800000, 32'hffc00000, 5'h10);
    issue(3'h1, 3'h0, 32'h00000000, 32'hc0000000, 32'hff800000, 5'h08);
    issue(3'h1, 3'h0, 32'h7f000000, 32'h00800000, 32'h00000000, 5'h02);
    issue(3'h1, 3'h0, 32'h00800000, 32'h7f000000, 32'h7f800000, 5'h04);
    issue(3'h1, 3'h0, 32'h3f800000, 32'h00000001, 32'hffc00000, 5'h01);
  end
  endtask
  task t_cmp(input [31:0] a, input [31:0] b, input [6:0] res, input [6:0] fl, input [4:0] f);
    integer s;
  begin
    for (s = 0; s < 7; s = s + 1)
      issue(3'h2, s[2:0], a, b, {31'h0, res[s]}, fl[s] ? f : 5'h00);
  end
  endtask
  task t_conv;
  begin
    issue(3'h3, 3'h0, 32'h00000007, 32'h0, 32'h40e00000, 5'h00);
    issue(3'h3, 3'h0, 32'hffffffff, 32'h0, 32'hbf800000, 5'h00);
    issue(3'h3, 3'h0, 32'h01000001, 32'h0, 32'h4b800000, 5'h00);
    issue(3'h4, 3'h0, 32'hc0200000, 32'h0, 32'hfffffffe, 5'h00);
    issue(3'h4, 3'h0, 32'hcf000000, 32'h0, 32'h80000000, 5'h00);
    issue(3'h4, 3'h0, 32'h4f000000, 32'h0, 32'hffc00000, 5'h10);
    issue(3'h4, 3'h0, 32'h7f800000, 32'h0, 32'hffc00000, 5'h10);
    issue(3'h4, 3'h0, 32'h7fc00000, 32'h0, 32'hffc00000, 5'h10);
  end
  endtask
  task t_unsup;
  begin
    @(posedge clk_sys);
    {go, go_op} <= {1'b1, 3'h5};
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk_w({30'h0, op_unsupported, op_ready}, 32'h2);
    @(posedge clk_sys);
    kill <= 1'b1;
    @(posedge clk_sys);
    kill <= 1'b0;
  end
  endtask
  initial
  begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs;
    t_mul;
    t_div;
    t_cmp(32'h3f800000, 32'h40000000, 7'h70, 7'h00, 5'h00);
    t_cmp(32'h40000000, 32'h3f800000, 7'h2a, 7'h00, 5'h00);
    t_cmp(32'h00000000, 32'h80000000, 7'h4c, 7'h00, 5'h00);
    t_cmp(32'h7f800001, 32'h3f800000, 7'h21, 7'h7f, 5'h10);
    t_cmp(32'h3f800000, 32'h7fc00000, 7'h21, 7'h5a, 5'h10);
    t_cmp(32'h00000001, 32'h3f800000, 7'h00, 7'h7f, 5'h01);
    t_conv;
    t_unsup;
    stop_test;
  end
endmodule
